// ==== bkp_pkg.sv ====
// Shared constants, types and helpers for the backplane bus handshake ends
package bkp_pkg;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int IOPG_W        = 13;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DESKEW_NS     = 8;
  localparam int DESKEW_CYC    = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC = 4;
  localparam int CNT_W         = 3;
  localparam int REFRESH_US    = 1600;
  localparam int REFRESH_CYC   = REFRESH_US * 1000 / CLK_PERIOD_NS;
  localparam int SYNC_RPLY     = 3;
  localparam int SYNC_IRQ      = 2;
  localparam int SYNC_DMR      = 1;
  localparam int SYNC_SACK     = 0;
  localparam logic [ADDR_W-1:0] DAL_RESET = 18'h00000;

  typedef enum logic [2:0] {
    M_IDLE, M_ADDR, M_SYNC, M_DATA, M_DESKEW, M_END, M_GRANT, M_DMA
  } mst_state_t;

  typedef enum logic [1:0] {
    S_IDLE, S_SEL, S_HOLD
  } opt_state_t;

  function automatic logic [ADDR_W-1:0] widen(input logic [DATA_W-1:0] d);
    return {{(ADDR_W-DATA_W){1'b0}}, d};
  endfunction
endpackage

// ==== bkp_if.sv ====
// Backplane wires resolved from both ends' open-drain enables
`timescale 1ns/1ps
interface bkp_if;
  import bkp_pkg::*;
  logic              m_sync_oe;
  logic              m_din_oe;
  logic              m_dout_oe;
  logic              m_wtbt_oe;
  logic              m_bs7_oe;
  logic              m_init_oe;
  logic              m_iak_oe;
  logic              m_dmg_oe;
  logic [ADDR_W-1:0] m_dal_o;
  logic [ADDR_W-1:0] m_dal_oe;
  logic              s_rply_oe;
  logic              s_irq_oe;
  logic              s_dmr_oe;
  logic              s_sack_oe;
  logic [ADDR_W-1:0] s_dal_o;
  logic [ADDR_W-1:0] s_dal_oe;
  logic              sync_n;
  logic              din_n;
  logic              dout_n;
  logic              wtbt_n;
  logic              bs7_n;
  logic              init_n;
  logic              iak_n;
  logic              dmg_n;
  logic              rply_n;
  logic              irq_n;
  logic              dmr_n;
  logic              sack_n;
  logic [ADDR_W-1:0] dal_n;

  // Any enabled driver pulls the line low; a DAL bit only where that driver's data bit is one
  assign sync_n = ~m_sync_oe;
  assign din_n  = ~m_din_oe;
  assign dout_n = ~m_dout_oe;
  assign wtbt_n = ~m_wtbt_oe;
  assign bs7_n  = ~m_bs7_oe;
  assign init_n = ~m_init_oe;
  assign iak_n  = ~m_iak_oe;
  assign dmg_n  = ~m_dmg_oe;
  assign rply_n = ~s_rply_oe;
  assign irq_n  = ~s_irq_oe;
  assign dmr_n  = ~s_dmr_oe;
  assign sack_n = ~s_sack_oe;
  assign dal_n  = ~((m_dal_oe & m_dal_o) | (s_dal_oe & s_dal_o));

  modport master (
    output m_sync_oe, m_din_oe, m_dout_oe, m_wtbt_oe, m_bs7_oe, m_init_oe,
    output m_iak_oe, m_dmg_oe, m_dal_o, m_dal_oe,
    input  rply_n, irq_n, dmr_n, sack_n, dal_n
  );
  modport option (
    output s_rply_oe, s_irq_oe, s_dmr_oe, s_sack_oe, s_dal_o, s_dal_oe,
    input  sync_n, din_n, dout_n, wtbt_n, bs7_n, init_n, iak_n, dmg_n, dal_n
  );
endinterface

// ==== bkp_master.sv ====
// Processor end: bus cycles, interrupt acknowledge, DMA arbitration, bus init
`timescale 1ns/1ps
module bkp_master (
  // Clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // Backplane
  bkp_if.master                          bus,
  // Cycle request
  input  wire logic                      req,
  input  wire logic                      req_write,
  input  wire logic                      req_byte,
  input  wire logic                      req_iopage,
  input  wire logic [bkp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [bkp_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                      iack_req,
  input  wire logic                      init_req,
  // Status and result
  output logic                           busy,
  output logic                           done,
  output logic [bkp_pkg::DATA_W-1:0]     rdata,
  output logic                           irq_pending,
  output logic                           dma_granted
);
  import bkp_pkg::*;

  mst_state_t        st_ff;
  logic [3:0]        s1_ff;
  logic [3:0]        s2_ff;
  logic              sync_ff;
  logic              din_ff;
  logic              dout_ff;
  logic              wtbt_ff;
  logic              bs7_ff;
  logic              iak_ff;
  logic              dmg_ff;
  logic              init_ff;
  logic              write_ff;
  logic              byte_ff;
  logic              done_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [ADDR_W-1:0] dal_o_ff;
  logic [ADDR_W-1:0] dal_oe_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              rply;
  logic              dmr;
  logic              sack;

  // Two-stage synchronisers for lines driven by other parties
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
    end else if (ce) begin
      s1_ff <= {~bus.rply_n, ~bus.irq_n, ~bus.dmr_n, ~bus.sack_n};
      s2_ff <= s1_ff;
    end
  end
  assign rply = s2_ff[SYNC_RPLY];
  assign dmr  = s2_ff[SYNC_DMR];
  assign sack = s2_ff[SYNC_SACK];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_ff <= 1'b0;
    end else if (ce) begin
      init_ff <= init_req;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff     <= M_IDLE;
      sync_ff   <= 1'b0;
      din_ff    <= 1'b0;
      dout_ff   <= 1'b0;
      wtbt_ff   <= 1'b0;
      bs7_ff    <= 1'b0;
      iak_ff    <= 1'b0;
      dmg_ff    <= 1'b0;
      write_ff  <= 1'b0;
      byte_ff   <= 1'b0;
      done_ff   <= 1'b0;
      cnt_ff    <= '0;
      dal_o_ff  <= DAL_RESET;
      dal_oe_ff <= DAL_RESET;
      rdata_ff  <= '0;
    end else if (ce) begin
      done_ff <= 1'b0;
      if (init_req) begin
        st_ff     <= M_IDLE;
        sync_ff   <= 1'b0;
        din_ff    <= 1'b0;
        dout_ff   <= 1'b0;
        wtbt_ff   <= 1'b0;
        bs7_ff    <= 1'b0;
        iak_ff    <= 1'b0;
        dmg_ff    <= 1'b0;
        dal_oe_ff <= DAL_RESET;
      end else begin
        case (st_ff)
          M_IDLE: begin
            if (dmr && !sack) begin
              dmg_ff <= 1'b1;
              st_ff  <= M_GRANT;
            end else if (iack_req) begin
              din_ff <= 1'b1;
              iak_ff <= 1'b1;
              st_ff  <= M_DATA;
            end else if (req) begin
              dal_o_ff  <= req_addr;
              dal_oe_ff <= '1;
              wtbt_ff   <= req_write;
              bs7_ff    <= req_iopage;
              write_ff  <= req_write;
              byte_ff   <= req_byte;
              st_ff     <= M_ADDR;
            end
          end
          M_ADDR: begin
            sync_ff <= 1'b1;
            cnt_ff  <= CNT_W'(ADDR_HOLD_CYC - 1);
            st_ff   <= M_SYNC;
          end
          M_SYNC: begin
            // Keep address until every slave has sampled it
            if (cnt_ff != '0) begin
              cnt_ff <= cnt_ff - 1'b1;
            end else begin
              bs7_ff    <= 1'b0;
              dal_o_ff  <= widen(req_wdata);
              dal_oe_ff <= write_ff ? widen({DATA_W{1'b1}}) : '0;
              wtbt_ff   <= write_ff & byte_ff;
              dout_ff   <= write_ff;
              din_ff    <= ~write_ff;
              st_ff     <= M_DATA;
            end
          end
          M_DATA: begin
            if (rply && write_ff && !iak_ff) begin
              dout_ff <= 1'b0;
              st_ff   <= M_END;
            end else if (rply) begin
              cnt_ff <= CNT_W'(DESKEW_CYC - 1);
              st_ff  <= M_DESKEW;
            end
          end
          M_DESKEW: begin
            if (cnt_ff != '0) begin
              cnt_ff <= cnt_ff - 1'b1;
            end else begin
              rdata_ff <= ~bus.dal_n[DATA_W-1:0];
              din_ff   <= 1'b0;
              st_ff    <= M_END;
            end
          end
          M_END: begin
            if (!rply) begin
              sync_ff   <= 1'b0;
              wtbt_ff   <= 1'b0;
              iak_ff    <= 1'b0;
              write_ff  <= 1'b0;
              dal_oe_ff <= '0;
              done_ff   <= 1'b1;
              st_ff     <= M_IDLE;
            end
          end
          M_GRANT: begin
            if (sack) begin
              dmg_ff <= 1'b0;
              st_ff  <= M_DMA;
            end else if (!dmr) begin
              dmg_ff <= 1'b0;
              st_ff  <= M_IDLE;
            end
          end
          M_DMA: begin
            if (!sack) begin
              st_ff <= M_IDLE;
            end
          end
          default: begin
            st_ff <= M_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.m_sync_oe = sync_ff;
  assign bus.m_din_oe  = din_ff;
  assign bus.m_dout_oe = dout_ff;
  assign bus.m_wtbt_oe = wtbt_ff;
  assign bus.m_bs7_oe  = bs7_ff;
  assign bus.m_init_oe = init_ff;
  assign bus.m_iak_oe  = iak_ff;
  assign bus.m_dmg_oe  = dmg_ff;
  assign bus.m_dal_o   = dal_o_ff;
  assign bus.m_dal_oe  = dal_oe_ff;
  assign busy          = (st_ff != M_IDLE);
  assign done          = done_ff;
  assign rdata         = rdata_ff;
  assign irq_pending   = s2_ff[SYNC_IRQ];
  assign dma_granted   = (st_ff == M_DMA);
endmodule

// ==== bkp_option.sv ====
// Option end: addressed slave, interrupt and DMA grant daisy-chain links
`timescale 1ns/1ps
module bkp_option #(
  parameter logic [bkp_pkg::IOPG_W-1:0] BASE_ADDR    = 13'h0000,
  parameter int                         MAX_HOLD_CYC = bkp_pkg::REFRESH_CYC
) (
  // Clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // Backplane
  bkp_if.option                          bus,
  // Chain outputs to the next option
  output logic                           iak_chain_out_n,
  output logic                           dmg_chain_out_n,
  // Register side
  input  wire logic [bkp_pkg::DATA_W-1:0] rd_data,
  output logic                           rd_stb,
  output logic                           wr_stb,
  output logic                           wr_byte,
  output logic [bkp_pkg::IOPG_W-1:0]     acc_addr,
  output logic [bkp_pkg::DATA_W-1:0]     wr_data,
  // Interrupt
  input  wire logic                      irq_req,
  input  wire logic [bkp_pkg::DATA_W-1:0] irq_vector,
  output logic                           irq_ack,
  // DMA
  input  wire logic                      dma_req,
  input  wire logic                      dma_done,
  output logic                           dma_owner,
  // Bus initialise seen
  output logic                           bus_init
);
  import bkp_pkg::*;

  localparam int HOLD_W = $clog2(MAX_HOLD_CYC + 1);

  opt_state_t        st_ff;
  logic [7:0]        s1_ff;
  logic [7:0]        s2_ff;
  logic [7:0]        s3_ff;
  logic              sync;
  logic              din;
  logic              dout;
  logic              wtbt;
  logic              bs7;
  logic              iaki;
  logic              dmgi;
  logic              init;
  logic              sync_rise;
  logic              iak_rise;
  logic              dmg_rise;
  logic              sel_hit;
  logic              rply_ff;
  logic [ADDR_W-1:0] dal_o_ff;
  logic [ADDR_W-1:0] dal_oe_ff;
  logic              rd_stb_ff;
  logic              wr_stb_ff;
  logic              wr_byte_ff;
  logic [IOPG_W-1:0] addr_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic              irq_ff;
  logic              irq_ack_ff;
  logic              iak_keep_ff;
  logic              iako_ff;
  logic              dmr_ff;
  logic              sack_ff;
  logic              dmg_keep_ff;
  logic              dmgo_ff;
  logic [HOLD_W-1:0] hold_ff;

  // Incoming strobes cross into the local clock; third stage for edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
    end else if (ce) begin
      s1_ff <= ~{bus.sync_n, bus.din_n, bus.dout_n, bus.wtbt_n,
                 bus.bs7_n, bus.iak_n, bus.dmg_n, bus.init_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign {sync, din, dout, wtbt, bs7, iaki, dmgi, init} = s2_ff;
  assign sync_rise = sync & ~s3_ff[7];
  assign iak_rise  = iaki & ~s3_ff[2];
  assign dmg_rise  = dmgi & ~s3_ff[1];
  assign sel_hit   = bs7 && (~bus.dal_n[IOPG_W-1:0] == BASE_ADDR);

  // Slave cycle handling
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff      <= S_IDLE;
      rply_ff    <= 1'b0;
      dal_o_ff   <= DAL_RESET;
      dal_oe_ff  <= DAL_RESET;
      rd_stb_ff  <= 1'b0;
      wr_stb_ff  <= 1'b0;
      wr_byte_ff <= 1'b0;
      addr_ff    <= '0;
      wr_data_ff <= '0;
      irq_ack_ff <= 1'b0;
    end else if (ce) begin
      rd_stb_ff  <= 1'b0;
      wr_stb_ff  <= 1'b0;
      irq_ack_ff <= 1'b0;
      if (init) begin
        st_ff      <= S_IDLE;
        rply_ff    <= 1'b0;
        dal_oe_ff  <= '0;
        wr_byte_ff <= 1'b0;
        addr_ff    <= '0;
        wr_data_ff <= '0;
      end else begin
        case (st_ff)
          S_IDLE: begin
            if (sync_rise && sel_hit) begin
              addr_ff <= ~bus.dal_n[IOPG_W-1:0];
              st_ff   <= S_SEL;
            end else if (din && !sync && iaki && iak_keep_ff) begin
              dal_o_ff   <= widen(irq_vector);
              dal_oe_ff  <= widen({DATA_W{1'b1}});
              rply_ff    <= 1'b1;
              irq_ack_ff <= 1'b1;
              st_ff      <= S_HOLD;
            end
          end
          S_SEL: begin
            if (!sync) begin
              st_ff <= S_IDLE;
            end else if (din) begin
              dal_o_ff  <= widen(rd_data);
              dal_oe_ff <= widen({DATA_W{1'b1}});
              rply_ff   <= 1'b1;
              rd_stb_ff <= 1'b1;
              st_ff     <= S_HOLD;
            end else if (dout) begin
              wr_data_ff <= ~bus.dal_n[DATA_W-1:0];
              wr_byte_ff <= wtbt;
              wr_stb_ff  <= 1'b1;
              rply_ff    <= 1'b1;
              st_ff      <= S_HOLD;
            end
          end
          S_HOLD: begin
            // Reply stands until the master takes its strobe away
            if (!din && !dout) begin
              rply_ff   <= 1'b0;
              dal_oe_ff <= '0;
              st_ff     <= S_SEL;
            end
          end
          default: begin
            st_ff <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Interrupt request and acknowledge chain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff      <= 1'b0;
      iak_keep_ff <= 1'b0;
      iako_ff     <= 1'b0;
    end else if (ce) begin
      if (init) begin
        irq_ff      <= 1'b0;
        iak_keep_ff <= 1'b0;
        iako_ff     <= 1'b0;
      end else begin
        irq_ff <= irq_req & ~irq_ack_ff;
        if (iak_rise) begin
          iak_keep_ff <= irq_ff;
          iako_ff     <= ~irq_ff;
        end else if (!iaki) begin
          iak_keep_ff <= 1'b0;
          iako_ff     <= 1'b0;
        end
      end
    end
  end

  // DMA request and grant chain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dmr_ff      <= 1'b0;
      sack_ff     <= 1'b0;
      dmg_keep_ff <= 1'b0;
      dmgo_ff     <= 1'b0;
      hold_ff     <= '0;
    end else if (ce) begin
      if (init) begin
        dmr_ff      <= 1'b0;
        sack_ff     <= 1'b0;
        dmg_keep_ff <= 1'b0;
        dmgo_ff     <= 1'b0;
        hold_ff     <= '0;
      end else begin
        if (dmg_rise) begin
          dmg_keep_ff <= dmr_ff;
          dmgo_ff     <= ~dmr_ff;
        end else if (!dmgi) begin
          dmg_keep_ff <= 1'b0;
          dmgo_ff     <= 1'b0;
        end
        if (dmg_rise && dmr_ff) begin
          dmr_ff  <= 1'b0;
          sack_ff <= 1'b1;
          hold_ff <= '0;
        end else if (sack_ff) begin
          // Bounded tenure keeps refresh cycles on time
          if (dma_done || hold_ff == HOLD_W'(MAX_HOLD_CYC - 1)) begin
            sack_ff <= 1'b0;
          end else begin
            hold_ff <= hold_ff + 1'b1;
          end
        end else begin
          dmr_ff <= dma_req & ~dmgi;
        end
      end
    end
  end

  assign bus.s_rply_oe  = rply_ff;
  assign bus.s_irq_oe   = irq_ff;
  assign bus.s_dmr_oe   = dmr_ff;
  assign bus.s_sack_oe  = sack_ff;
  assign bus.s_dal_o    = dal_o_ff;
  assign bus.s_dal_oe   = dal_oe_ff;
  assign iak_chain_out_n = ~iako_ff;
  assign dmg_chain_out_n = ~dmgo_ff;
  assign rd_stb         = rd_stb_ff;
  assign wr_stb         = wr_stb_ff;
  assign wr_byte        = wr_byte_ff;
  assign acc_addr       = addr_ff;
  assign wr_data        = wr_data_ff;
  assign irq_ack        = irq_ack_ff;
  assign dma_owner      = sack_ff;
  assign bus_init       = init;
endmodule

// ==== bkp_props.sv ====
// Wire-level handshake checks for the backplane bus
`timescale 1ns/1ps
module bkp_props
  import bkp_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              arst_n,
  // Resolved strobes and chains
  input wire logic              sync_n,
  input wire logic              din_n,
  input wire logic              dout_n,
  input wire logic              wtbt_n,
  input wire logic              init_n,
  input wire logic              iak_n,
  input wire logic              dmg_n,
  input wire logic              rply_n,
  input wire logic              dmr_n,
  input wire logic              sack_n,
  // Shared lines and drivers
  input wire logic [ADDR_W-1:0] dal_n,
  input wire logic [ADDR_W-1:0] m_dal_oe,
  input wire logic [ADDR_W-1:0] s_dal_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n || !init_n);

  property p_rply_strobe;
    $fell(rply_n) |-> (!din_n || !dout_n);
  endproperty
  a_rply_strobe: assert property (p_rply_strobe)
    else $error("reply without strobe");

  property p_read_wtbt;
    $fell(din_n) && !sync_n |-> wtbt_n;
  endproperty
  a_read_wtbt: assert property (p_read_wtbt)
    else $error("write select during input cycle");

  property p_sync_end;
    $rose(sync_n) |-> rply_n && $past(rply_n);
  endproperty
  a_sync_end: assert property (p_sync_end)
    else $error("sync ended before reply released");

  property p_addr_hold;
    $fell(sync_n) |-> $stable(dal_n) [*3];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address not held around sync");

  property p_iack_nosync;
    !iak_n |-> sync_n;
  endproperty
  a_iack_nosync: assert property (p_iack_nosync)
    else $error("acknowledge during sync");

  // Grant answers the request as seen through the master's two-flop sync
  property p_grant_idle;
    $fell(dmg_n) |-> sync_n && !$past(dmr_n, 3);
  endproperty
  a_grant_idle: assert property (p_grant_idle)
    else $error("grant without request or while busy");

  property p_sack_dmr;
    $fell(sack_n) |-> ##[0:2] dmr_n;
  endproperty
  a_sack_dmr: assert property (p_sack_dmr)
    else $error("request kept after taking mastership");

  property p_rply_bound;
    $fell(rply_n) |-> ##[1:40] rply_n;
  endproperty
  a_rply_bound: assert property (p_rply_bound)
    else $error("reply never released");

  property p_read_drive;
    $fell(rply_n) && !din_n |-> (|s_dal_oe) && (m_dal_oe == '0);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data lines not turned round");

  c_write: cover property ($fell(dout_n));
  c_read: cover property ($fell(din_n) && !sync_n);
  c_iack: cover property (!iak_n && !rply_n);
  c_dma: cover property ($fell(sack_n));
endmodule

// ==== backplane_bus_protocol_bench.sv ====
// Self-checking bench joining master and option ends
`timescale 1ns/1ps
module backplane_bus_protocol_bench;
  import bkp_pkg::*;
  localparam logic [IOPG_W-1:0] BASE = 13'h0040;
  localparam logic [ADDR_W-1:0] A    = 18'h3e040;
  localparam int                HOLD = 20;
  logic              core_clk, arst_n, ce, req, req_write, req_byte, req_iopage;
  logic              iack_req, init_req, irq_req, dma_req, dma_done;
  logic              busy, done, irq_pending, dma_granted, iak_chain_out_n, dmg_chain_out_n;
  logic              rd_stb, wr_stb, wr_byte, irq_ack, dma_owner, bus_init, got_wb;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rdata, rd_data, irq_vector, wr_data, got_wd;
  logic [IOPG_W-1:0] acc_addr, got_wa;
  int                num_errors, checked, n_wr, n_rd, n_ack;

  bkp_if bkp_if_i ();
  bkp_master bkp_master_i (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .bus(bkp_if_i.master),
    .req(req), .req_write(req_write), .req_byte(req_byte), .req_iopage(req_iopage),
    .req_addr(req_addr), .req_wdata(req_wdata), .iack_req(iack_req), .init_req(init_req),
    .busy(busy), .done(done), .rdata(rdata), .irq_pending(irq_pending),
    .dma_granted(dma_granted));
  bkp_option #(.BASE_ADDR(BASE), .MAX_HOLD_CYC(HOLD)) bkp_option_i (.core_clk(core_clk),
    .arst_n(arst_n), .ce(ce), .bus(bkp_if_i.option), .iak_chain_out_n(iak_chain_out_n),
    .dmg_chain_out_n(dmg_chain_out_n), .rd_data(rd_data), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wr_byte(wr_byte), .acc_addr(acc_addr), .wr_data(wr_data), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .dma_req(dma_req), .dma_done(dma_done),
    .dma_owner(dma_owner), .bus_init(bus_init));
  bkp_props bkp_props_i (.core_clk(core_clk), .arst_n(arst_n), .sync_n(bkp_if_i.sync_n),
    .din_n(bkp_if_i.din_n), .dout_n(bkp_if_i.dout_n), .wtbt_n(bkp_if_i.wtbt_n),
    .init_n(bkp_if_i.init_n), .iak_n(bkp_if_i.iak_n), .dmg_n(bkp_if_i.dmg_n),
    .rply_n(bkp_if_i.rply_n), .dmr_n(bkp_if_i.dmr_n), .sack_n(bkp_if_i.sack_n),
    .dal_n(bkp_if_i.dal_n), .m_dal_oe(bkp_if_i.m_dal_oe), .s_dal_oe(bkp_if_i.s_dal_oe));

  always #2 core_clk = ~core_clk;

  // Pulse counters on the option's user side
  always @(posedge core_clk) begin
    if (wr_stb === 1'b1) begin
      n_wr++;
      got_wd = wr_data;
      got_wa = acc_addr;
      got_wb = wr_byte;
    end
    if (rd_stb === 1'b1) n_rd++;
    if (irq_ack === 1'b1) n_ack++;
  end

  task automatic final_report;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic start(input logic wr, input logic by, input logic [DATA_W-1:0] d);
    int i;
    req_write = wr;
    req_byte = by;
    req_addr = A;
    req_wdata = d;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) cyc(1);
    chk(done, 1'b1);
  endtask

  task automatic t_write(input logic by, input logic [DATA_W-1:0] d);
    int n0;
    n0 = n_wr;
    start(1'b1, by, d);
    chk(n_wr - n0, 1);
    chk(got_wd, d);
    chk(got_wa, BASE);
    chk(got_wb, by);
  endtask

  task automatic t_read(input logic [DATA_W-1:0] d);
    int n0;
    n0 = n_rd;
    rd_data = d;
    start(1'b0, 1'b0, 16'h0000);
    chk(rdata, d);
    chk(n_rd - n0, 1);
  endtask

  task automatic t_iack;
    int i, n0;
    n0 = n_ack;
    irq_vector = 16'h01b4;
    irq_req = 1'b1;
    for (i = 0; i < 20 && irq_pending !== 1'b1; i++) cyc(1);
    chk(irq_pending, 1'b1);
    iack_req = 1'b1;
    cyc(1);
    iack_req = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) cyc(1);
    irq_req = 1'b0;
    chk(rdata, 16'h01b4);
    chk(n_ack - n0, 1);
    chk(iak_chain_out_n, 1'b1);
  endtask

  task automatic t_dma(input logic early);
    int i, n;
    dma_req = 1'b1;
    for (i = 0; i < 40 && dma_owner !== 1'b1; i++) cyc(1);
    chk(dma_owner, 1'b1);
    chk(dmg_chain_out_n, 1'b1);
    for (i = 0; i < 20 && dma_granted !== 1'b1; i++) cyc(1);
    chk(dma_granted, 1'b1);
    dma_req = 1'b0;
    if (early) begin
      cyc(3);
      dma_done = 1'b1;
      cyc(1);
      dma_done = 1'b0;
    end
    for (n = 0; n < 100 && dma_owner === 1'b1; n++) cyc(1);
    chk(dma_owner, 1'b0);
    chk(n <= HOLD, 1'b1);
    for (i = 0; i < 20 && dma_granted !== 1'b0; i++) cyc(1);
    chk(dma_granted, 1'b0);
  endtask

  // Request withdrawn before the grant arrives: grant is passed on
  task automatic t_dma_pass;
    int   i;
    logic seen;
    seen = 1'b0;
    dma_req = 1'b1;
    cyc(1);
    dma_req = 1'b0;
    for (i = 0; i < 20; i++) begin
      cyc(1);
      if (dmg_chain_out_n === 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(dma_owner, 1'b0);
  endtask

  // Access outside the I/O page is ignored; bus init frees the master
  task automatic t_nosel;
    int n0;
    n0 = n_wr;
    req_iopage = 1'b0;
    req_write = 1'b1;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(30);
    chk(n_wr - n0, 0);
    chk(bkp_if_i.rply_n, 1'b1);
    init_req = 1'b1;
    cyc(6);
    init_req = 1'b0;
    req_iopage = 1'b1;
    cyc(4);
    chk(busy, 1'b0);
  endtask

  // Clock enable low freezes the master: no cycle starts
  task automatic t_freeze;
    ce = 1'b0;
    req = 1'b1;
    cyc(3);
    chk(busy, 1'b0);
    chk(bkp_if_i.sync_n, 1'b1);
    req = 1'b0;
    ce = 1'b1;
  endtask

  // Unclaimed acknowledge passes on, master stuck until bus init
  task automatic t_pass_init;
    int i;
    iack_req = 1'b1;
    cyc(1);
    iack_req = 1'b0;
    for (i = 0; i < 20 && iak_chain_out_n !== 1'b0; i++) cyc(1);
    chk(iak_chain_out_n, 1'b0);
    init_req = 1'b1;
    for (i = 0; i < 20 && bus_init !== 1'b1; i++) cyc(1);
    cyc(3);
    chk(bus_init, 1'b1);
    chk(iak_chain_out_n, 1'b1);
    chk(busy, 1'b0);
    init_req = 1'b0;
    cyc(4);
    t_read(16'h8001);
  endtask

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    {req, req_write, req_byte, iack_req, init_req, irq_req, dma_req, dma_done} = '0;
    req_iopage = 1'b1;
    req_addr = '0;
    req_wdata = '0;
    rd_data = '0;
    irq_vector = '0;
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    cyc(1);
    chk({iak_chain_out_n, dmg_chain_out_n, bus_init, dma_owner}, 4'hc);
    t_freeze;
    t_write(1'b0, 16'ha5c3);
    t_write(1'b1, 16'h00ff);
    t_read(16'hffff);
    t_read(16'h0001);
    t_iack;
    t_dma(1'b1);
    t_dma(1'b0);
    t_dma_pass;
    t_write(1'b0, 16'h1234);
    t_nosel;
    t_pass_init;
    final_report;
  end

  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule
